// File: rtl/idw_pkg.sv
// constants for the identify parameter word table: register map,
// word indices, fixed word values and cycle-time floors.
// assumes a 32-bit APB register bus and a 16-bit word stream.
package idw_pkg;
  // register byte offsets
  localparam logic [11:0] IDW_CTRL_OFS   = 12'h000;
  localparam logic [11:0] IDW_STAT_OFS   = 12'h004;
  localparam logic [11:0] IDW_DGEOM_OFS  = 12'h008;
  localparam logic [11:0] IDW_SPT_OFS    = 12'h00c;
  localparam logic [11:0] IDW_CGEOM_OFS  = 12'h010;
  localparam logic [11:0] IDW_TOTAL_OFS  = 12'h014;
  localparam logic [11:0] IDW_MULT_OFS   = 12'h018;
  localparam logic [11:0] IDW_MODE_OFS   = 12'h01c;
  localparam logic [11:0] IDW_DMAT_OFS   = 12'h020;
  localparam logic [11:0] IDW_PIOT_OFS   = 12'h024;
  localparam logic [11:0] IDW_STRL_OFS   = 12'h028;
  localparam logic [11:0] IDW_SATA_OFS   = 12'h02c;
  localparam logic [3:0]  IDW_STR_PAGE   = 4'h1;
  // string store: serial chars 0..19, model chars 20..59
  localparam int          IDW_SER_LEN    = 20;
  localparam int          IDW_MDL_LEN    = 40;
  localparam int          IDW_STR_LEN    = 60;
  // field positions
  localparam int          IDW_CTRL_START = 0;
  localparam int          IDW_MULT_CUR   = 8;
  localparam int          IDW_MODE_DMA   = 0;
  localparam int          IDW_MODE_SUP   = 1;
  localparam int          IDW_MODE_SEL   = 4;
  localparam int          IDW_STRL_MDL   = 8;
  // reset values
  localparam logic [31:0] IDW_MULT_RST   = 32'h0000_0001;
  localparam logic [31:0] IDW_MODE_RST   = 32'h0000_0007;
  localparam logic [31:0] IDW_DMAT_RST   = 32'h0078_0078;
  localparam logic [15:0] IDW_PIOT_RST   = 16'h0078;
  localparam logic [15:0] IDW_SATA_RST   = 16'h0006;
  localparam logic [15:0] IDW_SATA_MASK  = 16'h0706;
  // word indices
  localparam logic [7:0]  W_GENCFG = 8'd0;
  localparam logic [7:0]  W_DCYL   = 8'd1;
  localparam logic [7:0]  W_DHEAD  = 8'd3;
  localparam logic [7:0]  W_DSPT   = 8'd6;
  localparam logic [7:0]  W_TOTHI  = 8'd7;
  localparam logic [7:0]  W_TOTLO  = 8'd8;
  localparam logic [7:0]  W_SER0   = 8'd10;
  localparam logic [7:0]  W_SER9   = 8'd19;
  localparam logic [7:0]  W_MDL0   = 8'd27;
  localparam logic [7:0]  W_MDL19  = 8'd46;
  localparam logic [7:0]  W_MULTMX = 8'd47;
  localparam logic [7:0]  W_CAPS   = 8'd49;
  localparam logic [7:0]  W_CAPS2  = 8'd50;
  localparam logic [7:0]  W_PIOLEG = 8'd51;
  localparam logic [7:0]  W_VALID  = 8'd53;
  localparam logic [7:0]  W_CCYL   = 8'd54;
  localparam logic [7:0]  W_CHEAD  = 8'd55;
  localparam logic [7:0]  W_CSPT   = 8'd56;
  localparam logic [7:0]  W_CCAPLO = 8'd57;
  localparam logic [7:0]  W_CCAPHI = 8'd58;
  localparam logic [7:0]  W_MULTST = 8'd59;
  localparam logic [7:0]  W_LBALO  = 8'd60;
  localparam logic [7:0]  W_LBAHI  = 8'd61;
  localparam logic [7:0]  W_MDMA   = 8'd63;
  localparam logic [7:0]  W_APIO   = 8'd64;
  localparam logic [7:0]  W_DMAMIN = 8'd65;
  localparam logic [7:0]  W_DMAREC = 8'd66;
  localparam logic [7:0]  W_PIONF  = 8'd67;
  localparam logic [7:0]  W_PIOFC  = 8'd68;
  localparam logic [7:0]  W_SATA   = 8'd76;
  localparam logic [7:0]  W_LAST   = 8'd255;
  // fixed word contents
  localparam logic [15:0] IDW_GENCFG_VAL = 16'h045a;
  localparam logic [15:0] IDW_CAPS_BASE  = 16'h0e00;
  localparam logic [15:0] IDW_CAPS2_VAL  = 16'h4000;
  localparam logic [15:0] IDW_PIOLEG_VAL = 16'h0200;
  localparam logic [15:0] IDW_VALID_VAL  = 16'h0007;
  localparam logic [15:0] IDW_MULTMX_HI  = 16'h8000;
  localparam logic [15:0] IDW_MULTST_VLD = 16'h0100;
  localparam logic [15:0] IDW_APIO_VAL   = 16'h0003;
  localparam logic [7:0]  IDW_PAD        = 8'h20;
  // cycle-time floors in ns per mode
  localparam logic [15:0] IDW_MDMA0_NS   = 16'd480;
  localparam logic [15:0] IDW_MDMA1_NS   = 16'd150;
  localparam logic [15:0] IDW_MDMA2_NS   = 16'd120;
  localparam logic [15:0] IDW_PIO4_NS    = 16'd120;

  typedef enum logic [0:0] {IDW_IDLE, IDW_SEND} idw_state_e;
endpackage

// File: rtl/idw_table.sv
// identify parameter word table with APB configuration registers.
// assumes a command decoder pulses identify_req_i and a link sink
// drains the word stream with a valid/ready handshake.
`timescale 1ns/100ps
module idw_table
  import idw_pkg::*;
(
  input  wire logic        clk_i,           // 20 MHz device clock
  input  wire logic        rst_n_i,         // async reset, active low
  input  wire logic        psel_i,          // apb select
  input  wire logic        penable_i,       // apb access phase
  input  wire logic        pwrite_i,        // apb write
  input  wire logic [11:0] paddr_i,         // apb byte address
  input  wire logic [31:0] pwdata_i,        // apb write data
  output logic      [31:0] prdata_o,        // apb read data
  output logic             pready_o,        // apb ready
  output logic             pslverr_o,       // apb error, unmapped
  input  wire logic        identify_req_i,  // start one table transfer
  output logic             word_valid_o,    // word on data is valid
  output logic      [15:0] word_data_o,     // parameter word
  output logic      [7:0]  word_index_o,    // index of that word
  output logic             word_last_o,     // word 255 on the bus
  input  wire logic        word_ready_i,    // sink takes the word
  output logic             busy_o           // transfer in progress
);

  // configuration state
  logic [15:0] dcyl_reg;
  logic [15:0] dhead_reg;
  logic [15:0] dspt_reg;
  logic [15:0] cspt_reg;
  logic [15:0] ccyl_reg;
  logic [15:0] chead_reg;
  logic [31:0] total_reg;
  logic [7:0]  multmx_reg;
  logic        multcur_reg;
  logic        dma_en_reg;
  logic [1:0]  mdma_sup_reg;
  logic [1:0]  mdma_sel_reg;
  logic [15:0] dmamin_reg;
  logic [15:0] dmarec_reg;
  logic [15:0] pionf_reg;
  logic [4:0]  ser_len_reg;
  logic [5:0]  mdl_len_reg;
  logic [15:0] sata_reg;
  logic [7:0]  str_mem [0:IDW_STR_LEN-1];

  // stream state
  idw_state_e  state_reg;
  logic [7:0]  idx_reg;
  logic [15:0] data_reg;

  // apb decode
  logic        setup;
  logic        wr_acc;
  logic        str_hit;
  logic [5:0]  str_idx;
  logic        reg_hit;
  logic        start;
  logic        fire;
  logic [7:0]  idx_next;

  assign setup   = psel_i & ~penable_i;
  assign wr_acc  = psel_i & penable_i & pwrite_i;
  assign str_idx = paddr_i[7:2];
  assign str_hit = (paddr_i[11:8] == IDW_STR_PAGE) && (str_idx < 6'(IDW_STR_LEN));
  assign pready_o = psel_i & penable_i;  // zero wait states

  // register offsets that answer without error
  always_comb begin
    case ({paddr_i[11:2], 2'b00})
      IDW_CTRL_OFS, IDW_STAT_OFS, IDW_DGEOM_OFS, IDW_SPT_OFS,
      IDW_CGEOM_OFS, IDW_TOTAL_OFS, IDW_MULT_OFS, IDW_MODE_OFS,
      IDW_DMAT_OFS, IDW_PIOT_OFS, IDW_STRL_OFS, IDW_SATA_OFS: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end

  // derived values
  logic [47:0] ccap_full;
  logic [31:0] ccap;
  logic [15:0] dma_floor;
  logic [15:0] dmamin_eff;
  logic [15:0] dmarec_eff;
  logic [15:0] pionf_eff;
  logic [1:0]  sel_eff;
  logic [7:0]  mdma_sel_bits;
  logic [7:0]  mdma_sup_bits;

  // truncated to 32 bits; geometry tables never exceed that
  assign ccap_full = {32'h0, ccyl_reg} * {32'h0, chead_reg} * {32'h0, cspt_reg};
  assign ccap      = ccap_full[31:0];

  // timing words clamped so software cannot report illegal values
  always_comb begin
    case (mdma_sup_reg)
      2'd3:    dma_floor = IDW_MDMA2_NS;
      2'd2:    dma_floor = IDW_MDMA1_NS;
      2'd1:    dma_floor = IDW_MDMA0_NS;
      default: dma_floor = 16'h0000;
    endcase
  end
  assign dmamin_eff = (mdma_sup_reg == 2'd0) ? 16'h0000 :
                      (dmamin_reg < dma_floor) ? dma_floor : dmamin_reg;
  assign dmarec_eff = (mdma_sup_reg == 2'd0) ? 16'h0000 :
                      (dmarec_reg < dmamin_eff) ? dmamin_eff : dmarec_reg;
  assign pionf_eff  = (pionf_reg < IDW_PIO4_NS) ? IDW_PIO4_NS : pionf_reg;

  // a selection above the supported mode shows no selection at all
  assign sel_eff = (mdma_sel_reg <= mdma_sup_reg) ? mdma_sel_reg : 2'd0;
  always_comb begin
    case (sel_eff)
      2'd1:    mdma_sel_bits = 8'h01;
      2'd2:    mdma_sel_bits = 8'h02;
      2'd3:    mdma_sel_bits = 8'h04;
      default: mdma_sel_bits = 8'h00;
    endcase
    case (mdma_sup_reg)
      2'd1:    mdma_sup_bits = 8'h01;
      2'd2:    mdma_sup_bits = 8'h03;
      2'd3:    mdma_sup_bits = 8'h07;
      default: mdma_sup_bits = 8'h00;
    endcase
  end

  // serial char p of 20, right justified
  function automatic logic [7:0] ser_char(input logic [5:0] p);
    logic [5:0] off;
    off = 6'(IDW_SER_LEN) - {1'b0, ser_len_reg};
    if (p < off) begin
      ser_char = IDW_PAD;
    end else begin
      ser_char = str_mem[p - off];
    end
  endfunction

  // model char p of 40, left justified
  function automatic logic [7:0] mdl_char(input logic [5:0] p);
    if (p < mdl_len_reg) begin
      mdl_char = str_mem[6'(IDW_SER_LEN) + p];
    end else begin
      mdl_char = IDW_PAD;
    end
  endfunction

  // content of word i; first char of a pair in the high byte
  function automatic logic [15:0] id_word(input logic [7:0] i);
    logic [5:0] p;
    p = 6'h00;
    id_word = 16'h0000;
    if (i >= W_SER0 && i <= W_SER9) begin
      p = 6'(i - W_SER0) << 1;
      id_word = {ser_char(p), ser_char(p + 6'd1)};
    end else if (i >= W_MDL0 && i <= W_MDL19) begin
      p = 6'(i - W_MDL0) << 1;
      id_word = {mdl_char(p), mdl_char(p + 6'd1)};
    end else begin
      case (i)
        W_GENCFG: id_word = IDW_GENCFG_VAL;
        W_DCYL:   id_word = dcyl_reg;
        W_DHEAD:  id_word = dhead_reg;
        W_DSPT:   id_word = dspt_reg;
        W_TOTHI:  id_word = total_reg[31:16];
        W_TOTLO:  id_word = total_reg[15:0];
        W_MULTMX: id_word = IDW_MULTMX_HI | {8'h00, multmx_reg};
        W_CAPS:   id_word = IDW_CAPS_BASE | {7'h00, dma_en_reg, 8'h00};
        W_CAPS2:  id_word = IDW_CAPS2_VAL;
        W_PIOLEG: id_word = IDW_PIOLEG_VAL;
        W_VALID:  id_word = IDW_VALID_VAL;
        W_CCYL:   id_word = ccyl_reg;
        W_CHEAD:  id_word = chead_reg;
        W_CSPT:   id_word = cspt_reg;
        W_CCAPLO: id_word = ccap[15:0];
        W_CCAPHI: id_word = ccap[31:16];
        W_MULTST: id_word = IDW_MULTST_VLD | {15'h0000, multcur_reg};
        W_LBALO:  id_word = total_reg[15:0];
        W_LBAHI:  id_word = total_reg[31:16];
        W_MDMA:   id_word = {mdma_sel_bits, mdma_sup_bits};
        W_APIO:   id_word = IDW_APIO_VAL;
        W_DMAMIN: id_word = dmamin_eff;
        W_DMAREC: id_word = dmarec_eff;
        W_PIONF:  id_word = pionf_eff;
        W_PIOFC:  id_word = IDW_PIO4_NS;
        W_SATA:   id_word = sata_reg & IDW_SATA_MASK;
        default:  id_word = 16'h0000;
      endcase
    end
  endfunction

  // apb register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dcyl_reg     <= 16'h0000;
      dhead_reg    <= 16'h0000;
      dspt_reg     <= 16'h0000;
      cspt_reg     <= 16'h0000;
      ccyl_reg     <= 16'h0000;
      chead_reg    <= 16'h0000;
      total_reg    <= 32'h0000_0000;
      multmx_reg   <= IDW_MULT_RST[7:0];
      multcur_reg  <= IDW_MULT_RST[IDW_MULT_CUR];
      dma_en_reg   <= IDW_MODE_RST[IDW_MODE_DMA];
      mdma_sup_reg <= IDW_MODE_RST[IDW_MODE_SUP +: 2];
      mdma_sel_reg <= IDW_MODE_RST[IDW_MODE_SEL +: 2];
      dmamin_reg   <= IDW_DMAT_RST[15:0];
      dmarec_reg   <= IDW_DMAT_RST[31:16];
      pionf_reg    <= IDW_PIOT_RST;
      ser_len_reg  <= 5'h00;
      mdl_len_reg  <= 6'h00;
      sata_reg     <= IDW_SATA_RST;
    end else if (wr_acc) begin
      case ({paddr_i[11:2], 2'b00})
        IDW_DGEOM_OFS: begin
          dcyl_reg  <= pwdata_i[15:0];
          dhead_reg <= pwdata_i[31:16];
        end
        IDW_SPT_OFS: begin
          dspt_reg <= pwdata_i[15:0];
          cspt_reg <= pwdata_i[31:16];
        end
        IDW_CGEOM_OFS: begin
          ccyl_reg  <= pwdata_i[15:0];
          chead_reg <= pwdata_i[31:16];
        end
        IDW_TOTAL_OFS: total_reg <= pwdata_i;
        IDW_MULT_OFS: begin
          multmx_reg  <= pwdata_i[7:0];
          multcur_reg <= pwdata_i[IDW_MULT_CUR];  // only 0 or 1 can be stored
        end
        IDW_MODE_OFS: begin
          dma_en_reg   <= pwdata_i[IDW_MODE_DMA];
          mdma_sup_reg <= pwdata_i[IDW_MODE_SUP +: 2];
          mdma_sel_reg <= pwdata_i[IDW_MODE_SEL +: 2];
        end
        IDW_DMAT_OFS: begin
          dmamin_reg <= pwdata_i[15:0];
          dmarec_reg <= pwdata_i[31:16];
        end
        IDW_PIOT_OFS: pionf_reg <= pwdata_i[15:0];
        IDW_STRL_OFS: begin
          // lengths saturate at the field size
          ser_len_reg <= (pwdata_i[4:0] > 5'd20) ? 5'd20 : pwdata_i[4:0];
          mdl_len_reg <= (pwdata_i[IDW_STRL_MDL +: 6] > 6'd40) ? 6'd40 :
                         pwdata_i[IDW_STRL_MDL +: 6];
        end
        IDW_SATA_OFS: sata_reg <= pwdata_i[15:0] & IDW_SATA_MASK;
        default: ;
      endcase
    end
  end

  // string store, one char per word in the low byte; no reset needed
  always_ff @(posedge clk_i) begin
    if (wr_acc && str_hit) begin
      str_mem[str_idx] <= pwdata_i[7:0];
    end
  end

  // read data and error captured in setup, shown during access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= ~(reg_hit | str_hit);
      prdata_o  <= 32'h0000_0000;
      if (str_hit) begin
        prdata_o <= {24'h000000, str_mem[str_idx]};
      end else if (!pwrite_i) begin
        case ({paddr_i[11:2], 2'b00})
          IDW_STAT_OFS:  prdata_o <= {15'h0000, word_valid_o, idx_reg, 7'h00, busy_o};
          IDW_DGEOM_OFS: prdata_o <= {dhead_reg, dcyl_reg};
          IDW_SPT_OFS:   prdata_o <= {cspt_reg, dspt_reg};
          IDW_CGEOM_OFS: prdata_o <= {chead_reg, ccyl_reg};
          IDW_TOTAL_OFS: prdata_o <= total_reg;
          IDW_MULT_OFS:  prdata_o <= {23'h000000, multcur_reg, multmx_reg};
          IDW_MODE_OFS:  prdata_o <= {26'h0000000, mdma_sel_reg, 1'b0, mdma_sup_reg, dma_en_reg};
          IDW_DMAT_OFS:  prdata_o <= {dmarec_reg, dmamin_reg};
          IDW_PIOT_OFS:  prdata_o <= {16'h0000, pionf_reg};
          IDW_STRL_OFS:  prdata_o <= {18'h00000, mdl_len_reg, 3'h0, ser_len_reg};
          IDW_SATA_OFS:  prdata_o <= {16'h0000, sata_reg};
          default:       prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a start is ignored while a transfer runs
  assign start = (state_reg == IDW_IDLE) &&
                 (identify_req_i || (wr_acc && ({paddr_i[11:2], 2'b00} == IDW_CTRL_OFS) &&
                  pwdata_i[IDW_CTRL_START]));
  assign fire     = word_valid_o & word_ready_i;
  assign idx_next = idx_reg + 8'd1;

  // stream sequencer: words 0..255 in order, data held until taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= IDW_IDLE;
      idx_reg   <= 8'h00;
      data_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        IDW_IDLE: begin
          if (start) begin
            state_reg <= IDW_SEND;
            idx_reg   <= W_GENCFG;
            data_reg  <= id_word(W_GENCFG);
          end
        end
        IDW_SEND: begin
          if (fire) begin
            if (idx_reg == W_LAST) begin
              state_reg <= IDW_IDLE;
              idx_reg   <= 8'h00;
            end else begin
              idx_reg  <= idx_next;
              data_reg <= id_word(idx_next);
            end
          end
        end
        default: state_reg <= IDW_IDLE;
      endcase
    end
  end

  assign word_valid_o = (state_reg == IDW_SEND);
  assign word_data_o  = data_reg;
  assign word_index_o = idx_reg;
  assign word_last_o  = word_valid_o && (idx_reg == W_LAST);
  assign busy_o       = word_valid_o;

endmodule

// File: verification/idw_table_props.sv
// concurrent checks on the identify word table ports.
// assumes one clock domain and the designer's zero-wait apb slave.
`timescale 1ns/100ps
module idw_table_props
  import idw_pkg::*;
(
  input wire logic        clk_i,          // device clock
  input wire logic        rst_n_i,        // async reset, active low
  input wire logic        psel_i,         // apb select
  input wire logic        penable_i,      // apb access phase
  input wire logic        pwrite_i,       // apb write
  input wire logic [11:0] paddr_i,        // apb address
  input wire logic [31:0] pwdata_i,       // apb write data
  input wire logic [31:0] prdata_o,       // apb read data
  input wire logic        pready_o,       // apb ready
  input wire logic        pslverr_o,      // apb error
  input wire logic        identify_req_i, // start request
  input wire logic        word_valid_o,   // word offered
  input wire logic [15:0] word_data_o,    // word content
  input wire logic [7:0]  word_index_o,   // word index
  input wire logic        word_last_o,    // final word
  input wire logic        word_ready_i,   // sink ready
  input wire logic        busy_o          // transfer running
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] w65_reg;
  logic [15:0] w67_reg;
  logic        hs;
  assign hs = word_valid_o && word_ready_i;
  // remember earlier words, since the ordering checks span two words
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w65_reg <= 16'h0;
      w67_reg <= 16'h0;
    end else if (hs) begin
      if (word_index_o == W_DMAMIN) w65_reg <= word_data_o;
      if (word_index_o == W_PIONF) w67_reg <= word_data_o;
    end
  end
  chk_apb_ready: assert property (psel_i && penable_i |-> pready_o)
    else $error("apb ready missing in access");
  chk_unmapped_err: assert property (psel_i && penable_i && paddr_i[11:8] == 4'h0 && paddr_i[7:2] > 6'd11
    |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
  chk_start_word0: assert property (identify_req_i && !word_valid_o |=> word_valid_o &&
    word_index_o == W_GENCFG && word_data_o == IDW_GENCFG_VAL && word_data_o[6]) else $error("bad first word");
  chk_index_step: assert property (hs && !word_last_o |=> word_valid_o &&
    word_index_o == $past(word_index_o) + 8'd1) else $error("index did not advance by one");
  chk_stall_hold: assert property (word_valid_o && !word_ready_i |=> word_valid_o &&
    $stable(word_data_o) && $stable(word_index_o)) else $error("word changed while stalled");
  chk_last_end: assert property (hs && word_last_o |=> !word_valid_o && !busy_o)
    else $error("stream went on after last word");
  chk_last_flag: assert property (word_valid_o |-> word_last_o == (word_index_o == W_LAST))
    else $error("last flag on wrong word");
  chk_caps_bits: assert property (word_valid_o && word_index_o == W_CAPS |->
    word_data_o[13:9] == 5'b00111) else $error("capability bits wrong");
  chk_legacy_pio: assert property (word_valid_o && word_index_o == W_PIOLEG |-> word_data_o[15:8] == 8'h02)
    else $error("legacy pio byte wrong");
  chk_valid_bits: assert property (word_valid_o && word_index_o == W_VALID |-> word_data_o[2:0] == 3'b111)
    else $error("validity bits wrong");
  chk_mult_set: assert property (word_valid_o && word_index_o == W_MULTST |->
    word_data_o[15:8] == 8'h01 && word_data_o[7:1] == 7'h0) else $error("multiple setting word wrong");
  chk_mdma_fields: assert property (word_valid_o && word_index_o == W_MDMA |->
    $countones(word_data_o[15:8]) <= 1 && word_data_o[15:11] == 5'h0 && word_data_o[7:3] == 5'h0 &&
    word_data_o[2:0] inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("dma mode word malformed");
  chk_dma_rec: assert property (word_valid_o && word_index_o == W_DMAREC |-> word_data_o >= w65_reg)
    else $error("recommended dma time below minimum");
  chk_pio_fc: assert property (word_valid_o && word_index_o == W_PIOFC |->
    word_data_o <= w67_reg && word_data_o == IDW_PIO4_NS) else $error("pio cycle words inconsistent");
  chk_sata_rsv: assert property (word_valid_o && word_index_o == W_SATA |->
    word_data_o[15:11] == 5'h0 && word_data_o[7:3] == 5'h0 && !word_data_o[0]) else $error("link word reserved set");
  cov_last: cover property (hs && word_last_o);
  cov_stall: cover property (word_valid_o && !word_ready_i);
  cov_err: cover property (psel_i && penable_i && pslverr_o);
endmodule

bind idw_table idw_table_props i_idw_table_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .identify_req_i(identify_req_i), .word_valid_o(word_valid_o), .word_data_o(word_data_o),
  .word_index_o(word_index_o), .word_last_o(word_last_o), .word_ready_i(word_ready_i), .busy_o(busy_o));

// File: verification/idw_link_sink.sv
// link-side sink standing in for the host controller: takes words,
// stores them by index, counts them and flags any break in order.
// assumes the valid/ready word stream of the table.
`timescale 1ns/100ps
module idw_link_sink (
  input  wire logic        clk_i,        // device clock
  input  wire logic        rst_n_i,      // async reset, active low
  input  wire logic        stall_i,      // slow mode, ready one cycle in four
  input  wire logic        word_valid_i, // word offered
  input  wire logic [15:0] word_data_i,  // word content
  input  wire logic [7:0]  word_index_i, // word index
  output logic             word_ready_o, // word taken
  output logic      [8:0]  count_o,      // words in this transfer
  output logic             order_err_o   // index out of order seen
);
  logic [15:0] mem [0:255];
  logic [1:0]  phase_reg;
  logic [7:0]  prev_reg;
  // ready pattern; a slow host exercises the hold-while-stalled path
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg    <= 2'h0;
      word_ready_o <= 1'b0;
    end else begin
      phase_reg    <= phase_reg + 2'h1;
      word_ready_o <= !stall_i || phase_reg == 2'h2;
    end
  end
  // capture and order tracking; index 0 opens a new transfer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o     <= 9'h0;
      order_err_o <= 1'b0;
      prev_reg    <= 8'h0;
    end else if (word_valid_i && word_ready_o) begin
      mem[word_index_i] <= word_data_i;
      prev_reg          <= word_index_i;
      count_o           <= (word_index_i == 8'h0) ? 9'h1 : count_o + 9'h1;
      if (word_index_i != 8'h0 && word_index_i != prev_reg + 8'h1) order_err_o <= 1'b1;
    end
  end
endmodule

// File: verification/identify_device_word_table_test.sv
// self-checking bench for the identify word table: apb master,
// link sink, word table rows, reset, refusal and stall cases.
// assumes the design's zero-wait apb slave and valid/ready stream.
`timescale 1ns/100ps
module identify_device_word_table_test
  import idw_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, ident, stall, pready, perr, valid, last, ready, busy, oerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] wdata;
  logic [7:0]  widx;
  logic [8:0]  cnt;
  logic        e;
  int          mismatches = 0;
  int          num_checks = 0;
  logic [43:0] cfg [0:9] = '{{IDW_DGEOM_OFS, 32'h0010_03e0}, {IDW_SPT_OFS, 32'h003f_003f},
    {IDW_CGEOM_OFS, 32'h0010_03e0}, {IDW_TOTAL_OFS, 32'h0012_3456}, {IDW_MULT_OFS, 32'h0000_0110},
    {IDW_MODE_OFS, 32'h0000_0027}, {IDW_DMAT_OFS, 32'h0096_0064}, {IDW_PIOT_OFS, 32'h0000_0064},
    {IDW_SATA_OFS, 32'h0000_ffff}, {IDW_STRL_OFS, 32'h0000_0403}};
  // rows of word index beside the word expected for the config above
  logic [23:0] rows [0:30] = '{24'h00_045a, 24'h01_03e0, 24'h03_0010, 24'h06_003f,
    24'h07_0012, 24'h08_3456, 24'h0a_2020, 24'h12_2041, 24'h13_4243,
    24'h1b_5556, 24'h1c_5758, 24'h2e_2020, 24'h2f_8010, 24'h31_0f00,
    24'h32_4000, 24'h33_0200, 24'h35_0007, 24'h36_03e0, 24'h39_4200, 24'h3a_000f,
    24'h3b_0101, 24'h3c_3456, 24'h3d_0012, 24'h3f_0207, 24'h40_0003,
    24'h41_0078, 24'h42_0096, 24'h43_0078, 24'h44_0078, 24'h4c_0706, 24'h ff_0000};
  logic [43:0] rst_tab [0:5] = '{{IDW_MULT_OFS, IDW_MULT_RST}, {IDW_MODE_OFS, IDW_MODE_RST},
    {IDW_DMAT_OFS, IDW_DMAT_RST}, {IDW_PIOT_OFS, 16'h0, IDW_PIOT_RST}, {IDW_SATA_OFS, 16'h0, IDW_SATA_RST},
    {IDW_TOTAL_OFS, 32'h0}};

  always #25 clk = ~clk;

  idw_table i_idw_table (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .identify_req_i(ident), .word_valid_o(valid), .word_data_o(wdata), .word_index_o(widx),
    .word_last_o(last), .word_ready_i(ready), .busy_o(busy));
  idw_link_sink i_idw_link_sink (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .word_valid_i(valid),
    .word_data_i(wdata), .word_index_i(widx), .word_ready_o(ready), .count_o(cnt), .order_err_o(oerr));

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // one apb transfer, held until pready is high, then an idle cycle
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e  = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // bounded wait for the word stream to finish
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      give_verdict();
    end
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, ident, stall} = 6'h0;
    paddr  = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (cfg[i]) apb(cfg[i][43:32], 1'b1, cfg[i][31:0]);
    for (int n = 0; n < IDW_STR_LEN; n++) apb(12'h100 + 12'(4 * n), 1'b1, 32'h41 + 32'(n));
    ident <= 1'b1;
    @(posedge clk);
    ident <= 1'b0;
    @(posedge clk);
    wait_idle();
    chk("word count", 32'd256, {23'h0, cnt});
    chk("order flag", 32'h0, {31'h0, oerr});
    foreach (rows[r]) chk("word", {16'h0, rows[r][15:0]}, {16'h0, i_idw_link_sink.mem[rows[r][23:16]]});
    // second reset after the transfer has finished, then register reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rst_tab[i]) begin
      apb(rst_tab[i][43:32], 1'b0, 32'h0);
      chk("reset value", rst_tab[i][31:0], rd);
    end
    apb(12'h030, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, rd);
    apb(12'h1f0, 1'b0, 32'h0);
    chk("string range err", 32'h1, {31'h0, e});
    apb(IDW_STAT_OFS, 1'b1, 32'hffff_ffff);
    apb(IDW_STAT_OFS, 1'b0, 32'h0);
    chk("status idle", 32'h0, rd);
    // no dma support with a mode selected, slow host, start by register
    apb(IDW_MODE_OFS, 1'b1, 32'h0000_0020);
    apb(IDW_MULT_OFS, 1'b1, 32'h0000_0005);
    stall <= 1'b1;
    apb(IDW_CTRL_OFS, 1'b1, 32'h1);
    apb(IDW_STAT_OFS, 1'b0, 32'h0);
    chk("status busy", 32'h1, {31'h0, rd[0]});
    ident <= 1'b1;
    @(posedge clk);
    ident <= 1'b0;
    wait_idle();
    repeat (3) @(posedge clk);
    chk("ignored start", 32'h0, {31'h0, busy});
    chk("stalled count", 32'd256, {23'h0, cnt});
    chk("stalled order", 32'h0, {31'h0, oerr});
    chk("w47", 32'h8005, {16'h0, i_idw_link_sink.mem[47]});
    chk("w49", 32'h0e00, {16'h0, i_idw_link_sink.mem[49]});
    chk("w59", 32'h0100, {16'h0, i_idw_link_sink.mem[59]});
    chk("w63", 32'h0, {16'h0, i_idw_link_sink.mem[63]});
    chk("w65", 32'h0, {16'h0, i_idw_link_sink.mem[65]});
    chk("w66", 32'h0, {16'h0, i_idw_link_sink.mem[66]});
    chk("w76", 32'h0006, {16'h0, i_idw_link_sink.mem[76]});
    apb(IDW_MODE_OFS, 1'b1, 32'h0000_0033);
    apb(IDW_CTRL_OFS, 1'b1, 32'h1);
    wait_idle();
    chk("w63b", 32'h0001, {16'h0, i_idw_link_sink.mem[63]});
    chk("w65b", 32'd480, {16'h0, i_idw_link_sink.mem[65]});
    chk("w66b", 32'd480, {16'h0, i_idw_link_sink.mem[66]});
    give_verdict();
  end
endmodule
